/* File: hdl/ppcd_top.sv */
// Printer parallel port receiver and control code interpreter
// Function
// R1: Error output low on paper end, off-line or fault, high otherwise.
// R2: Data accepted only while select-in low; switch 1-8 forces it low. Code also accepts with select-in high while selected.
// R3: Host sends only after acknowledge or while busy is low.
// R4: Standard coding table used while switch 2-4 is off (default).
// R5: Carriage return prints line; feeds if auto-feed low or switch 2-2.
// R6: Printable byte past full line prints buffer; feeds if auto-feed.
// R7: Line feed prints buffer then feeds; blank buffer only feeds.
// R8: Vertical tab prints and goes to next stop, else acts as LF.
// R9: Form feed prints and goes to top of form; default form length.
// R10: Shift-out gives double width until printed or DC4.
// R11: Shift-in condenses whole line until DC2; capacity 132 columns.
// R12: Shift-out while condensed gives condensed double; DC4 undoes it.
// R13: Horizontal tab moves to next stop; ignored when no stop set.
// R14: Cancel (if switch 1-4 allows) discards buffer and clears SO.
// R15: Delete (if switch 1-5 allows) behaves as cancel.
// R16: DC1 selects; when already selected it discards buffered data.
// R17: DC3 deselects; nothing stored until next DC1.
// R18: Users of DC1/DC3 set switch 1-8 off.
// R19: DC1/DC3 honoured only while select-in is high.
// R20: Low acknowledge about 5 us per byte; busy during entry, print, error.
// R21: Host presents data then strobes low; data latched while low.
// R22: Init low resets controller and clears the buffer.
// R23: Control codes recognised at their seven-bit ASCII values.
// R24: Init or power-up clears size modes and sets selected.
`include "ppcd_consts.svh"
module ppcd_top import ppcd_pkg::*; #(
   parameter int ACK_CYCLES = (`PPCD_ACK_PULSE_NS * `PPCD_CLK_MHZ) / 1000,
   parameter logic [7:0] FORM_LEN_DEFAULT = `PPCD_FORM_LEN_DEF
) (
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic STROBE_N_IN,
   input wire logic [7:0] DATA_IN,
   input wire logic INIT_N_IN,
   input wire logic SELECT_INPUT_N_IN,
   input wire logic AUTO_LINE_ADVANCE_N_IN,
   input wire logic PAPER_OUT_IN,
   input wire logic ONLINE_IN,
   input wire logic MECH_FAULT_IN,
   input wire logic PRINT_DONE_IN,
   input wire logic [7:0] PRINT_RD_ADDR_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   output logic BYTE_TAKEN_PULSE_N_OUT,
   output logic BUSY_OUT,
   output logic ERROR_N_OUT,
   output logic PAPER_OUT_OUT,
   output logic SELECTED_OUTPUT_OUT,
   output logic PRINT_REQ_OUT,
   output logic [7:0] PRINT_LEN_OUT,
   output logic [1:0] PRINT_FEED_OUT,
   output logic PRINT_CONDENSED_OUT,
   output logic [7:0] PRINT_FORM_LEN_OUT,
   output logic [8:0] PRINT_RD_DATA_OUT
);
   ppcd_state_t state_ff, nxt_state;
   logic soft_rst;
   logic strobe_prev_ff;
   logic [7:0] byte_ff;
   logic [7:0] col_ff;
   logic nonspace_ff;
   logic dbl_ff;
   logic cond_ff;
   logic line_cond_ff;
   logic selected_ff;
   logic pend_ff;
   logic ack_start_ff;
   logic [7:0] cfg_ff;
   logic [7:0] htab_ff;
   logic [7:0] form_ff;
   logic err_cond;
   logic sel_in_low;
   logic accept;
   logic [7:0] code;
   logic printable;
   logic [7:0] cap;
   logic auto_feed;
   logic cr_feed;
   logic go_print;
   logic go_tab;
   logic do_store;
   logic do_discard;
   logic do_dc1;
   logic do_dc3;
   ppcd_feed_t feed_kind;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [8:0] wr_data;
   logic ack_busy;
   logic wb_req;
   logic [31:0] stat_word;

   // Init pin is treated as a synchronous soft reset [R22]
   assign soft_rst = SYS_RST_IN | ~INIT_N_IN;
   assign err_cond = PAPER_OUT_IN | ~ONLINE_IN | MECH_FAULT_IN; // [R1]
   assign sel_in_low = cfg_ff[`PPCD_CFG_SW1_8] | ~SELECT_INPUT_N_IN; // [R2]
   // Select-in high still allows entry while selected by DC1
   assign accept = sel_in_low | selected_ff; // [R2]
   // Alternate table keeps bit 7; standard table is seven-bit
   assign code = cfg_ff[`PPCD_CFG_SW2_4] ? byte_ff
      : {1'b0, byte_ff[6:0]}; // [R4]
   assign printable = code >= `PPCD_CODE_SPACE && code != `PPCD_CODE_DEL;
   assign cap = line_cond_ff ? `PPCD_COLS_COND : `PPCD_COLS_NORM; // [R11]
   assign auto_feed = ~AUTO_LINE_ADVANCE_N_IN | cfg_ff[`PPCD_CFG_SW2_3];
   assign cr_feed = ~AUTO_LINE_ADVANCE_N_IN | cfg_ff[`PPCD_CFG_SW2_2];

   // Decode of the latched byte, only meaningful in ST_DECODE
   always_comb begin
      go_print = 1'b0;
      go_tab = 1'b0;
      do_store = 1'b0;
      do_discard = 1'b0;
      do_dc1 = 1'b0;
      do_dc3 = 1'b0;
      feed_kind = FEED_NONE;
      if (state_ff == ST_DECODE) begin
         case (code) // [R23]
            `PPCD_CODE_CR: begin
               go_print = accept;
               feed_kind = cr_feed ? FEED_LINE : FEED_NONE; // [R5]
            end
            `PPCD_CODE_LF: begin
               go_print = accept;
               feed_kind = FEED_LINE; // [R7]
            end
            `PPCD_CODE_VT: begin
               go_print = accept;
               feed_kind = cfg_ff[`PPCD_CFG_VTAB] ? FEED_VTAB
                  : FEED_LINE; // [R8]
            end
            `PPCD_CODE_FF: begin
               go_print = accept;
               feed_kind = FEED_FORM; // [R9]
            end
            `PPCD_CODE_HT: begin
               go_tab = accept && htab_ff != 8'h00 && col_ff < htab_ff
                  && htab_ff <= cap; // [R13]
            end
            `PPCD_CODE_CAN: begin
               do_discard = accept & ~cfg_ff[`PPCD_CFG_SW1_4]; // [R14]
            end
            `PPCD_CODE_DEL: begin
               do_discard = accept & ~cfg_ff[`PPCD_CFG_SW1_5]; // [R15]
            end
            `PPCD_CODE_DC1: begin
               do_dc1 = ~sel_in_low; // [R19]
            end
            `PPCD_CODE_DC3: begin
               do_dc3 = ~sel_in_low; // [R19]
            end
            default: begin
               if (accept && printable) begin
                  if (col_ff >= cap) begin
                     go_print = 1'b1; // [R6]
                     feed_kind = auto_feed ? FEED_LINE : FEED_NONE;
                  end else begin
                     do_store = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Byte entry handshake and sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // Falling strobe seen while low: data is stable [R21]
            if (strobe_prev_ff && !STROBE_N_IN && !err_cond) begin
               nxt_state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            if (go_print) begin
               nxt_state = ST_PRINT;
            end else if (go_tab) begin
               nxt_state = ST_TAB;
            end else begin
               nxt_state = ST_ACK;
            end
         end
         ST_TAB: begin
            if (col_ff + 8'h01 >= htab_ff) begin
               nxt_state = ST_ACK;
            end
         end
         ST_PRINT: begin
            if (PRINT_DONE_IN) begin
               nxt_state = ST_ACK;
            end
         end
         ST_ACK: begin
            if (!ack_start_ff && !ack_busy) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         strobe_prev_ff <= 1'b1;
         byte_ff <= 8'h00;
      end else begin
         strobe_prev_ff <= STROBE_N_IN;
         if (state_ff == ST_IDLE && !STROBE_N_IN) begin
            byte_ff <= DATA_IN; // [R21]
         end
      end
   end

   // One pulse per byte taken, also for bytes not stored [R20]
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         ack_start_ff <= 1'b0;
      end else begin
         ack_start_ff <= nxt_state == ST_ACK && state_ff != ST_ACK;
      end
   end

   // Buffer write port: stored char, tab space, or deferred char
   always_comb begin
      wr_en = 1'b0;
      wr_addr = col_ff;
      wr_data = {dbl_ff, code};
      if (do_store) begin
         wr_en = 1'b1;
      end else if (state_ff == ST_TAB) begin
         wr_en = 1'b1;
         wr_data = {dbl_ff, `PPCD_CODE_SPACE}; // [R13]
      end else if (state_ff == ST_PRINT && PRINT_DONE_IN && pend_ff) begin
         wr_en = 1'b1;
         wr_addr = 8'h00;
         wr_data = {1'b0, code}; // [R6]
      end
   end

   // Column count and blank-line tracking
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         col_ff <= 8'h00; // [R22]
         nonspace_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else if (do_discard || (do_dc1 && selected_ff)) begin
         col_ff <= 8'h00; // [R14] [R16]
         nonspace_ff <= 1'b0;
      end else if (do_store) begin
         col_ff <= col_ff + 8'h01;
         nonspace_ff <= nonspace_ff | (code != `PPCD_CODE_SPACE);
      end else if (state_ff == ST_TAB) begin
         col_ff <= col_ff + 8'h01;
      end else if (go_print) begin
         pend_ff <= state_ff == ST_DECODE && printable
            && code != `PPCD_CODE_HT; // [R6]
      end else if (state_ff == ST_PRINT && PRINT_DONE_IN) begin
         col_ff <= pend_ff ? 8'h01 : 8'h00;
         nonspace_ff <= pend_ff && code != `PPCD_CODE_SPACE;
         pend_ff <= 1'b0;
      end
   end

   // Print size modes
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         dbl_ff <= 1'b0; // [R24]
         cond_ff <= 1'b0;
         line_cond_ff <= 1'b0;
      end else if (state_ff == ST_DECODE && accept) begin
         if (code == `PPCD_CODE_SO) begin
            dbl_ff <= 1'b1; // [R10] [R12]
         end
         if (code == `PPCD_CODE_DC4 || do_discard || go_print) begin
            dbl_ff <= 1'b0; // [R10] [R14]
         end
         if (code == `PPCD_CODE_SI) begin
            cond_ff <= 1'b1; // [R11]
            line_cond_ff <= 1'b1;
         end
         if (code == `PPCD_CODE_DC2) begin
            cond_ff <= 1'b0; // [R11]
         end
      end else if (state_ff == ST_PRINT && PRINT_DONE_IN) begin
         line_cond_ff <= cond_ff; // [R11]
      end
   end

   // Selection by DC1/DC3
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         selected_ff <= 1'b1; // [R24]
      end else if (do_dc1) begin
         selected_ff <= 1'b1; // [R16]
      end else if (do_dc3) begin
         selected_ff <= 1'b0; // [R17]
      end
   end

   // Print request to the mechanism, one-cycle pulse
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         PRINT_REQ_OUT <= 1'b0;
         PRINT_LEN_OUT <= 8'h00;
         PRINT_FEED_OUT <= FEED_NONE;
         PRINT_CONDENSED_OUT <= 1'b0;
      end else begin
         PRINT_REQ_OUT <= go_print;
         if (go_print) begin
            // Blank line sends no columns, only paper motion [R7]
            PRINT_LEN_OUT <= nonspace_ff ? col_ff : 8'h00;
            PRINT_FEED_OUT <= feed_kind;
            PRINT_CONDENSED_OUT <= line_cond_ff |
               (code == `PPCD_CODE_SI);
         end
      end
   end

   // Status pins
   always_ff @(posedge CORE_CLK_IN) begin
      if (soft_rst) begin
         BUSY_OUT <= 1'b1;
         ERROR_N_OUT <= 1'b1;
         PAPER_OUT_OUT <= 1'b0;
         SELECTED_OUTPUT_OUT <= 1'b0;
         PRINT_FORM_LEN_OUT <= FORM_LEN_DEFAULT;
      end else begin
         BUSY_OUT <= err_cond || nxt_state != ST_IDLE; // [R20]
         ERROR_N_OUT <= ~err_cond; // [R1]
         PAPER_OUT_OUT <= PAPER_OUT_IN;
         SELECTED_OUTPUT_OUT <= ONLINE_IN & selected_ff;
         PRINT_FORM_LEN_OUT <= form_ff; // [R9]
      end
   end

   ppcd_line_buffer #(
      .WIDTH(9),
      .DEPTH(132)
   ) u_buf (
      .clk_in(CORE_CLK_IN),
      .wr_en_in(wr_en),
      .wr_addr_in(wr_addr),
      .wr_data_in(wr_data),
      .rd_addr_in(PRINT_RD_ADDR_IN),
      .rd_data_out(PRINT_RD_DATA_OUT)
   );

   ppcd_ack_pulse #(
      .CYCLES(ACK_CYCLES)
   ) u_ack (
      .clk_in(CORE_CLK_IN),
      .rst_in(soft_rst),
      .start_in(ack_start_ff), // [R20]
      .pulse_n_out(BYTE_TAKEN_PULSE_N_OUT),
      .busy_out(ack_busy)
   );

   // Wishbone slave, answers one cycle after the request
   assign wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[`PPCD_ST_SEL] = selected_ff;
      stat_word[`PPCD_ST_DBL] = dbl_ff;
      stat_word[`PPCD_ST_COND] = cond_ff;
      stat_word[`PPCD_ST_LCOND] = line_cond_ff;
      stat_word[`PPCD_ST_BUSY] = BUSY_OUT;
      stat_word[`PPCD_ST_ERR_N] = ERROR_N_OUT;
      stat_word[`PPCD_ST_COL_LSB +: 8] = col_ff;
   end

   // Bus registers survive the init pin; only system reset clears them
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         cfg_ff <= `PPCD_CFG_RST; // [R2] [R4]
         htab_ff <= 8'h00;
         form_ff <= FORM_LEN_DEFAULT;
      end else if (wb_req && WB_WE_IN && WB_SEL_IN[0]) begin
         case (WB_ADR_IN)
            `PPCD_ADR_CFG: cfg_ff <= WB_DAT_IN[7:0];
            `PPCD_ADR_HTAB: htab_ff <= WB_DAT_IN[7:0];
            `PPCD_ADR_FORM: form_ff <= WB_DAT_IN[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= 32'h0000_0000;
      end else begin
         WB_ACK_OUT <= wb_req;
         if (wb_req && !WB_WE_IN) begin
            case (WB_ADR_IN)
               `PPCD_ADR_CFG: WB_DAT_OUT <= {24'h000000, cfg_ff};
               `PPCD_ADR_HTAB: WB_DAT_OUT <= {24'h000000, htab_ff};
               `PPCD_ADR_FORM: WB_DAT_OUT <= {24'h000000, form_ff};
               `PPCD_ADR_STAT: WB_DAT_OUT <= stat_word;
               default: WB_DAT_OUT <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // ppcd_top

/* File: common/ppcd_consts.svh */
// Constants for the printer port control decoder
`ifndef PPCD_CONSTS_SVH
`define PPCD_CONSTS_SVH
`define PPCD_CODE_LF 8'h0A
`define PPCD_CODE_VT 8'h0B
`define PPCD_CODE_FF 8'h0C
`define PPCD_CODE_CR 8'h0D
`define PPCD_CODE_SO 8'h0E
`define PPCD_CODE_SI 8'h0F
`define PPCD_CODE_DC1 8'h11
`define PPCD_CODE_DC2 8'h12
`define PPCD_CODE_DC3 8'h13
`define PPCD_CODE_DC4 8'h14
`define PPCD_CODE_HT 8'h09
`define PPCD_CODE_CAN 8'h18
`define PPCD_CODE_DEL 8'h7F
`define PPCD_CODE_SPACE 8'h20
`define PPCD_COLS_NORM 8'h50
`define PPCD_COLS_COND 8'h84
`define PPCD_FORM_LEN_DEF 8'h42
`define PPCD_ACK_PULSE_NS 5000
`define PPCD_CLK_MHZ 200
`define PPCD_ADR_CFG 8'h00
`define PPCD_ADR_HTAB 8'h04
`define PPCD_ADR_FORM 8'h08
`define PPCD_ADR_STAT 8'h0C
`define PPCD_CFG_RST 8'h0E
`define PPCD_CFG_SW1_4 0
`define PPCD_CFG_SW1_5 1
`define PPCD_CFG_SW1_8 2
`define PPCD_CFG_SW2_2 3
`define PPCD_CFG_SW2_3 4
`define PPCD_CFG_SW2_4 5
`define PPCD_CFG_VTAB 6
`define PPCD_ST_SEL 0
`define PPCD_ST_DBL 1
`define PPCD_ST_COND 2
`define PPCD_ST_LCOND 3
`define PPCD_ST_BUSY 4
`define PPCD_ST_ERR_N 5
`define PPCD_ST_COL_LSB 8
`endif

/* File: common/ppcd_pkg.sv */
// Types shared by the printer port control decoder
package ppcd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DECODE,
      ST_TAB,
      ST_PRINT,
      ST_ACK
   } ppcd_state_t;
   typedef enum logic [1:0] {
      FEED_NONE,
      FEED_LINE,
      FEED_VTAB,
      FEED_FORM
   } ppcd_feed_t;
endpackage

/* File: hdl/ppcd_line_buffer.sv */
// Line buffer: one write port, registered read port
module ppcd_line_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 132
) (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [7:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [7:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_in) begin
      if (wr_en_in && wr_addr_in < 8'(DEPTH)) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Out of range reads give zero rather than an unknown word
   always_ff @(posedge clk_in) begin
      if (rd_addr_in < 8'(DEPTH)) begin
         rd_data_out <= mem[rd_addr_in];
      end else begin
         rd_data_out <= '0;
      end
   end
endmodule // ppcd_line_buffer

/* File: hdl/ppcd_ack_pulse.sv */
// Acknowledge pulse generator, active low
module ppcd_ack_pulse #(
   parameter int CYCLES = 1000
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   output logic pulse_n_out,
   output logic busy_out
);
   logic [15:0] cnt_ff;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_ff <= 16'h0000;
         pulse_n_out <= 1'b1;
      end else if (start_in) begin
         cnt_ff <= 16'(CYCLES);
         pulse_n_out <= 1'b0;
      end else if (cnt_ff != 16'h0000) begin
         cnt_ff <= cnt_ff - 16'h0001;
         pulse_n_out <= (cnt_ff == 16'h0001);
      end
   end

   assign busy_out = (cnt_ff != 16'h0000);
endmodule // ppcd_ack_pulse

/* File: testbench/ppcd_top_sva.sv */
// Checker bound to the printer port control decoder top
module ppcd_top_sva #(
   parameter int ACK_CYCLES = 1000
) (
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic INIT_N_IN,
   input wire logic STROBE_N_IN,
   input wire logic PAPER_OUT_IN,
   input wire logic ONLINE_IN,
   input wire logic MECH_FAULT_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_ACK_OUT,
   input wire logic BYTE_TAKEN_PULSE_N_OUT,
   input wire logic BUSY_OUT,
   input wire logic ERROR_N_OUT,
   input wire logic PAPER_OUT_OUT,
   input wire logic SELECTED_OUTPUT_OUT
);
   logic rst;
   logic flt;
   logic [15:0] low_cnt_ff;
   assign rst = SYS_RST_IN || !INIT_N_IN;
   assign flt = PAPER_OUT_IN || !ONLINE_IN || MECH_FAULT_IN;
   default clocking @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (rst);
   always_ff @(posedge CORE_CLK_IN) begin
      if (rst || BYTE_TAKEN_PULSE_N_OUT) begin
         low_cnt_ff <= 16'h0000;
      end else begin
         low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
   end
   a_err_low: assert property (flt [*3] |-> !ERROR_N_OUT)
      else $error("error output high during a fault");
   a_err_high: assert property (!flt [*3] |-> ERROR_N_OUT)
      else $error("error output low without a fault");
   a_paper_err: assert property (PAPER_OUT_IN [*3]
      |-> PAPER_OUT_OUT && !ERROR_N_OUT)
      else $error("paper out not reported");
   a_busy_fault: assert property (flt [*3] |-> BUSY_OUT)
      else $error("busy low during a fault");
   a_ack_busy: assert property (!BYTE_TAKEN_PULSE_N_OUT |-> BUSY_OUT)
      else $error("busy low during acknowledge");
   a_ack_width: assert property ($rose(BYTE_TAKEN_PULSE_N_OUT)
      |-> low_cnt_ff == 16'(ACK_CYCLES))
      else $error("acknowledge pulse width wrong");
   a_take_busy: assert property ($fell(STROBE_N_IN) && !BUSY_OUT
      && ERROR_N_OUT |-> ##[1:2] BUSY_OUT)
      else $error("strobe taken without busy");
   a_sel_offline: assert property (!ONLINE_IN [*3]
      |-> !SELECTED_OUTPUT_OUT)
      else $error("selected while off line");
   a_wb_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
      |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
      else $error("bus answer not one cycle later");
endmodule // ppcd_top_sva
bind ppcd_top ppcd_top_sva #(.ACK_CYCLES(ACK_CYCLES)) chk_u (.*);

/* File: testbench/ppcd_host_model.sv */
// Host parallel adapter model that strobes bytes into the printer
module ppcd_host_model (
   input wire logic clk_in,
   input wire logic busy_in,
   output logic strobe_n_out,
   output logic [7:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      strobe_n_out = 1'b1;
      data_out = 8'hA5;
   end
   task automatic ready();
      while (busy_in !== 1'b0) begin
         @(posedge clk_in);
      end
   endtask
   task automatic send(input logic [7:0] b);
      ready();
      data_out <= b;
      @(posedge clk_in);
      strobe_n_out <= 1'b0;
      repeat (101) @(posedge clk_in);
      strobe_n_out <= 1'b1;
      @(posedge clk_in);
      data_out <= ~b;
      @(posedge clk_in);
      ready();
   endtask
endmodule // ppcd_host_model

/* File: testbench/printer_port_control_decoder_tb.sv */
// Self-checking bench for the printer port control decoder
`include "ppcd_consts.svh"
module printer_port_control_decoder_tb import ppcd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, init_n = 1'b1, online = 1'b1;
   logic afeed_n = 1'b1, sel_n = 1'b0, paper = 1'b0, mfault = 1'b0;
   logic done = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, rd_adr = 8'h00, data, plen, pform, p_len;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic strobe_n, ack, ackn, busy, err_n, pout, seld, preq, pcond, p_cond;
   logic [1:0] pfeed, p_feed;
   logic [8:0] prdat;
   int fails = 0, num_checks = 0, p_cnt = 0, prints = 0;
   always #2.5 clk = ~clk;
   ppcd_top #(.ACK_CYCLES(8)) dut_u (
      .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .STROBE_N_IN(strobe_n),
      .DATA_IN(data), .INIT_N_IN(init_n), .SELECT_INPUT_N_IN(sel_n),
      .AUTO_LINE_ADVANCE_N_IN(afeed_n), .PAPER_OUT_IN(paper),
      .ONLINE_IN(online), .MECH_FAULT_IN(mfault), .PRINT_DONE_IN(done),
      .PRINT_RD_ADDR_IN(rd_adr), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .BYTE_TAKEN_PULSE_N_OUT(ackn),
      .BUSY_OUT(busy), .ERROR_N_OUT(err_n), .PAPER_OUT_OUT(pout),
      .SELECTED_OUTPUT_OUT(seld), .PRINT_REQ_OUT(preq),
      .PRINT_LEN_OUT(plen), .PRINT_FEED_OUT(pfeed),
      .PRINT_CONDENSED_OUT(pcond), .PRINT_FORM_LEN_OUT(pform),
      .PRINT_RD_DATA_OUT(prdat));
   ppcd_host_model host_u (.clk_in(clk), .busy_in(busy),
      .strobe_n_out(strobe_n), .data_out(data));
   // Mechanism stand-in
   always @(posedge clk) begin
      done <= preq;
      if (done === 1'b1) begin
         p_len <= plen;
         p_feed <= pfeed;
         p_cond <= pcond;
         p_cnt <= p_cnt + 1;
      end
   end
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic put(input string s);
      for (int i = 0; i < s.len(); i++) begin
         host_u.send(s[i]);
      end
   endtask
   task automatic code(input logic [7:0] c);
      host_u.send(c);
   endtask
   // Column and {condensed, double}
   task automatic mode(input logic [7:0] c, input logic [1:0] m);
      wb(1'b0, `PPCD_ADR_STAT, 32'h0);
      check(32'({c, m}), 32'({q[15:8], q[2:1]}));
   endtask
   task automatic pr(input logic [7:0] len, input logic [1:0] f);
      prints++;
      check(32'(prints), 32'(p_cnt));
      check(32'({len, f}), 32'({p_len, p_feed}));
   endtask
   task automatic t_reset();
      check(32'h6, 32'({seld, err_n, busy}));
      wb(1'b0, `PPCD_ADR_CFG, 32'h0);
      check(32'h0E, q);
      wb(1'b0, `PPCD_ADR_FORM, 32'h0);
      check(32'h42, q);
      wb(1'b0, `PPCD_ADR_HTAB, 32'h0);
      check(32'h00, q);
      wb(1'b0, `PPCD_ADR_STAT, 32'h0);
      check(32'h21, q);
      wb(1'b1, 8'h10, 32'hFF);
      wb(1'b0, 8'h10, 32'h0);
      check(32'h0, q);
   endtask
   task automatic t_fault();
      for (int i = 0; i < 3; i++) begin
         paper <= (i == 0);
         online <= (i != 1);
         mfault <= (i == 2);
         repeat (4) @(posedge clk);
         check(32'({i != 1, 1'b0, 1'b1, i == 0}),
            32'({seld, err_n, busy, pout}));
      end
      mfault <= 1'b0;
      repeat (4) @(posedge clk);
      check(32'h6, 32'({seld, err_n, busy}));
   endtask
   task automatic t_cr();
      wb(1'b1, `PPCD_ADR_CFG, 32'h00);
      put("AB");
      code(`PPCD_CODE_CR);
      pr(8'h02, FEED_NONE);
      afeed_n <= 1'b0;
      put("C");
      code(`PPCD_CODE_CR);
      pr(8'h01, FEED_LINE);
      afeed_n <= 1'b1;
      wb(1'b1, `PPCD_ADR_CFG, 32'h08);
      put("D");
      code(`PPCD_CODE_CR);
      pr(8'h01, FEED_LINE);
   endtask
   task automatic t_feed();
      code(`PPCD_CODE_LF);
      pr(8'h00, FEED_LINE);
      put("  ");
      code(`PPCD_CODE_LF);
      pr(8'h00, FEED_LINE);
      put("A");
      code(`PPCD_CODE_VT);
      pr(8'h01, FEED_LINE);
      wb(1'b1, `PPCD_ADR_CFG, 32'h40);
      code(`PPCD_CODE_VT);
      pr(8'h00, FEED_VTAB);
      put("AB");
      code(`PPCD_CODE_FF);
      pr(8'h02, FEED_FORM);
      check(32'h42, 32'(pform));
   endtask
   task automatic t_full();
      for (int i = 0; i < 80; i++) begin
         code(8'h58);
      end
      check(32'(prints), 32'(p_cnt));
      put("Y");
      pr(8'h50, FEED_NONE);
      mode(8'h01, 2'h0);
      code(`PPCD_CODE_CR);
      pr(8'h01, FEED_NONE);
      code(`PPCD_CODE_SI);
      for (int i = 0; i < 132; i++) begin
         code(8'h58);
      end
      check(32'(prints), 32'(p_cnt));
      afeed_n <= 1'b0;
      put("Y");
      pr(8'h84, FEED_LINE);
      check(32'h1, 32'(p_cond));
      afeed_n <= 1'b1;
      code(`PPCD_CODE_DC2);
      code(`PPCD_CODE_CAN);
   endtask
   task automatic t_size();
      code(`PPCD_CODE_SO);
      put("A");
      code(`PPCD_CODE_DC4);
      code(8'hC2);
      for (int i = 0; i < 2; i++) begin
         rd_adr <= 8'(i);
         repeat (2) @(posedge clk);
         check(i ? 32'h042 : 32'h141, 32'(prdat));
      end
      code(`PPCD_CODE_SO);
      code(`PPCD_CODE_CR);
      pr(8'h02, FEED_NONE);
      mode(8'h00, 2'h0);
      code(`PPCD_CODE_SI);
      code(`PPCD_CODE_SO);
      mode(8'h00, 2'h3);
      code(`PPCD_CODE_DC4);
      mode(8'h00, 2'h2);
      code(`PPCD_CODE_DC2);
      mode(8'h00, 2'h0);
   endtask
   task automatic t_cancel();
      put("AB");
      code(`PPCD_CODE_SI);
      code(`PPCD_CODE_SO);
      code(`PPCD_CODE_CAN);
      mode(8'h00, 2'h2);
      put("C");
      code(`PPCD_CODE_DEL);
      mode(8'h00, 2'h2);
      wb(1'b1, `PPCD_ADR_CFG, 32'h03);
      put("C");
      code(`PPCD_CODE_CAN);
      mode(8'h01, 2'h2);
      code(`PPCD_CODE_DC2);
      code(`PPCD_CODE_CR);
      pr(8'h01, FEED_NONE);
   endtask
   task automatic t_select();
      wb(1'b1, `PPCD_ADR_CFG, 32'h00);
      sel_n <= 1'b1;
      put("AB");
      code(`PPCD_CODE_DC1);
      mode(8'h00, 2'h0);
      code(`PPCD_CODE_DC3);
      put("C");
      check(32'h0, 32'(seld));
      mode(8'h00, 2'h0);
      code(`PPCD_CODE_DC1);
      put("D");
      check(32'h1, 32'(seld));
      sel_n <= 1'b0;
      code(`PPCD_CODE_DC3);
      put("E");
      check(32'h1, 32'(seld));
      mode(8'h02, 2'h0);
      code(`PPCD_CODE_CAN);
   endtask
   task automatic t_ht();
      put("A");
      code(`PPCD_CODE_HT);
      mode(8'h01, 2'h0);
      wb(1'b1, `PPCD_ADR_HTAB, 32'h05);
      code(`PPCD_CODE_HT);
      mode(8'h05, 2'h0);
      code(`PPCD_CODE_CAN);
   endtask
   task automatic t_init();
      sel_n <= 1'b1;
      code(`PPCD_CODE_SI);
      code(`PPCD_CODE_SO);
      put("AB");
      code(`PPCD_CODE_DC3);
      init_n <= 1'b0;
      @(posedge clk);
      init_n <= 1'b1;
      repeat (2) @(posedge clk);
      wb(1'b0, `PPCD_ADR_STAT, 32'h0);
      check(32'h21, q);
      wb(1'b0, `PPCD_ADR_HTAB, 32'h0);
      check(32'h05, q);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_fault();
      t_cr();
      t_feed();
      t_full();
      t_size();
      t_cancel();
      t_select();
      t_ht();
      t_init();
      complete_run();
   end
   // Run takes about 30k cycles
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      complete_run();
   end
endmodule // printer_port_control_decoder_tb
